// *** core/fbe_pkg.sv ***
// Shared constants and types for the flash block erase controller
package fbe_pkg;

    // Clock and erase timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int ERASE_TIME_NS = 2_000_000;
    localparam int ERASE_CYCLES  = ERASE_TIME_NS / CLK_PERIOD_NS;

    // Block geometry of the table pointer
    localparam int BLOCK_BYTES = 64;
    localparam int TP_WIDTH    = 22;
    localparam int BLK_LSB     = 6;
    localparam int BLK_WIDTH   = TP_WIDTH - BLK_LSB;

    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_KEY  = 5'h04;
    localparam logic [4:0] OFS_TPTR = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0C;
    localparam logic [4:0] OFS_MASK = 5'h10;

    // Unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic mem_sel;
        logic cfg_sel;
        logic rsvd;
        logic block_clear;
        logic fault;
        logic permit;
        logic prog_go;
        logic fetch_go;
    } fbe_ctrl_t;

    // Event status and mask layout
    typedef struct packed {
        logic [5:0] rsvd;
        logic       fault;
        logic       done;
    } fbe_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG  = 2'b10
    } fbe_state_t;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b10
    } fbe_key_t;

    // Command to the flash array
    typedef struct packed {
        logic                 erase;
        logic                 write;
        logic                 mem_sel;
        logic                 cfg_sel;
        logic [BLK_WIDTH-1:0] block;
    } fbe_nvm_cmd_t;

    // Whole state of the top module
    typedef struct packed {
        fbe_state_t            st;
        fbe_ctrl_t             ctl;
        logic [TP_WIDTH-1:0]   tptr;
        logic [BLK_WIDTH-1:0]  blk;
        fbe_evt_t              stat;
        fbe_evt_t              mask;
        logic                  rd_ack;
        logic [31:0]           rdata;
    } fbe_top_t;

    localparam fbe_ctrl_t CTRL_RESET = 8'h00;
    localparam fbe_top_t  TOP_RESET  = '0;

endpackage : fbe_pkg

// *** core/fbe_unlock.sv ***
// Two-write unlock key detector
`timescale 1ns/100ps
module fbe_unlock
    import fbe_pkg::*;
(
    // System
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clear,
    // Key port writes
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    // Start attempt uses up the key
    input  wire logic       consume,
    output logic            armed
);

    typedef struct packed {
        fbe_key_t ks;
    } fbe_unl_t;

    fbe_unl_t s;
    fbe_unl_t next_s;

    always_comb begin
        next_s = s;
        if (key_wr) begin
            unique case (s.ks)
                KEY_HALF: begin
                    if (key_data == KEY_SECOND)
                        next_s.ks = KEY_ARMED;
                    else if (key_data == KEY_FIRST)
                        next_s.ks = KEY_HALF;
                    else
                        next_s.ks = KEY_IDLE;
                end
                KEY_IDLE, KEY_ARMED: begin
                    next_s.ks = (key_data == KEY_FIRST) ? KEY_HALF
                                                        : KEY_IDLE;
                end
                default: next_s.ks = KEY_IDLE;
            endcase
        end
        // One start per key sequence
        if (consume || clear)
            next_s.ks = KEY_IDLE;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            s <= '{ks: KEY_IDLE};
        else
            s <= next_s;
    end

    assign armed = (s.ks == KEY_ARMED);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_key_order: assert property (
        $rose(armed) |-> $past(key_wr) && $past(key_data) == KEY_SECOND
            && $past(s.ks) == KEY_HALF)
        else $error("unlock armed without 55h then AAh");

endmodule : fbe_unlock

// *** core/fbe_timer.sv ***
// Self-timed programming cycle timer
`timescale 1ns/100ps
module fbe_timer #(
    parameter int CYCLES = 50000
) (
    // System
    input  wire logic clock,
    input  wire logic rst,
    // Control
    input  wire logic start,
    input  wire logic abort,
    // Status
    output logic      busy,
    output logic      done
);

    localparam int CW = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 2) begin : g_bad
            $error("fbe_timer: CYCLES must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
    } fbe_tmr_t;

    fbe_tmr_t s;
    fbe_tmr_t next_s;

    // Done fires in the last counted cycle so the cycle is exact
    assign done = s.busy && (s.cnt == '0);
    assign busy = s.busy;

    always_comb begin
        next_s = s;
        if (abort) begin
            next_s.busy = 1'b0;
            next_s.cnt  = '0;
        end else if (start && !s.busy) begin
            next_s.busy = 1'b1;
            next_s.cnt  = CW'(CYCLES - 1);
        end else if (done) begin
            next_s.busy = 1'b0;
        end else if (s.busy) begin
            next_s.cnt = s.cnt - CW'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_timer_expiry: assert property (
        done |-> s.cnt == '0 && s.busy ##1 !s.busy || $past(start))
        else $error("timer did not end on expiry");

endmodule : fbe_timer

// *** core/fbe_block_erase.sv ***
// Flash block erase controller with Avalon-MM register access
//
// Functional notes
// - An erase always clears one whole 64-byte block, in whichever memory mem_sel and cfg_sel select.
// - The block comes from pointer bits 21:6; bits 5:0 are ignored.
// - No single-word erase exists; the block is the smallest unit.
// - Only a 55h then AAh key write pair lets the go bit start.
// - Go with block clear selected begins erasing the block.
// - The processor stalls for the whole erase, about 2 ms.
// - The cycle ends by itself when the internal timer expires.
// - Block clear chooses erase and is cleared when the erase ends.
// - No program or erase cycle starts unless permit is set.
// - Fetch go is set by software only, cleared by hardware, blocked
//      while memory or configuration select is set.
`timescale 1ns/100ps
module fbe_block_erase
    import fbe_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_CYCLES
) (
    // System
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         dev_reset,
    // Avalon-MM slave
    input  wire logic [4:0]   address,
    input  wire logic         read,
    input  wire logic         write,
    input  wire logic [31:0]  writedata,
    input  wire logic [3:0]   byteenable,
    output logic [31:0]       readdata,
    output logic              waitrequest,
    // Flash array and core
    output fbe_nvm_cmd_t      nvm_cmd,
    output logic              eeprom_read,
    output logic              cpu_stall,
    // Interrupt
    output logic              irq
);

    fbe_top_t  s;
    fbe_top_t  next_s;
    fbe_ctrl_t wc;
    logic      key_armed;
    logic      key_wr;
    logic      consume;
    logic      t_start;
    logic      t_abort;
    logic      t_busy;
    logic      t_done;
    logic      busy;
    logic      ctrl_wr;
    logic      rd_take;
    logic [31:0] rd_mux;
    logic [31:0] tptr_merged;
    int        stall_len;

    // Stall assertion below wants eight cycles at least
    generate
        if (ERASE_CYC < 8) begin : g_bad_cyc
            $error("fbe_block_erase: ERASE_CYC must be at least 8");
        end
    endgenerate

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] fbe_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i])
                r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction : fbe_merge

    // Write-one-to-clear on the low byte of an event register
    function automatic fbe_evt_t fbe_w1c(
        input fbe_evt_t    old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        fbe_evt_t r;
        r = old;
        if (be[0])
            r = old & ~fbe_evt_t'(wd[7:0]);
        r.rsvd = '0;
        return r;
    endfunction : fbe_w1c

    assign busy    = (s.st != ST_IDLE);
    assign key_wr  = write && (address == OFS_KEY) && byteenable[0];
    assign ctrl_wr = write && (address == OFS_CTRL) && byteenable[0];
    assign rd_take = read && !s.rd_ack;
    assign wc      = fbe_ctrl_t'(writedata[7:0]);
    assign tptr_merged = fbe_merge({{(32-TP_WIDTH){1'b0}}, s.tptr},
                                   writedata, byteenable);

    fbe_unlock u_unlock (
        .clock    (clock),
        .rst      (rst),
        .clear    (dev_reset),
        .key_wr   (key_wr),
        .key_data (writedata[7:0]),
        .consume  (consume),
        .armed    (key_armed)
    );

    fbe_timer #(
        .CYCLES (ERASE_CYC)
    ) u_timer (
        .clock (clock),
        .rst   (rst),
        .start (t_start),
        .abort (t_abort),
        .busy  (t_busy),
        .done  (t_done)
    );

    // Read multiplexer; unmapped and key offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (address)
            OFS_CTRL: rd_mux = {24'h00_0000, s.ctl};
            OFS_TPTR: rd_mux = {{(32-TP_WIDTH){1'b0}}, s.tptr};
            OFS_STAT: rd_mux = {24'h00_0000, s.stat};
            OFS_MASK: rd_mux = {24'h00_0000, s.mask};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s  = s;
        consume = 1'b0;
        t_start = 1'b0;
        t_abort = 1'b0;

        // Fetch go lasts a single cycle
        // hardware clear
        next_s.ctl.fetch_go = 1'b0;

        // One wait state on reads, none on writes
        next_s.rd_ack = rd_take;
        if (rd_take)
            next_s.rdata = rd_mux;

        // Control writes are frozen while a cycle runs
        if (ctrl_wr && !busy) begin
            next_s.ctl.mem_sel     = wc.mem_sel;
            next_s.ctl.cfg_sel     = wc.cfg_sel;
            next_s.ctl.block_clear = wc.block_clear;
            next_s.ctl.permit      = wc.permit;
            next_s.ctl.fault       = wc.fault;
            if (wc.fetch_go && !s.ctl.mem_sel && !s.ctl.cfg_sel)
                next_s.ctl.fetch_go = 1'b1;
            // Any go attempt spends the key, so a refused try needs
            // a fresh sequence
            // key gates go
            if (wc.prog_go) begin
                consume = 1'b1;
                if (key_armed && s.ctl.permit) begin
                    next_s.ctl.prog_go = 1'b1;
                    t_start            = 1'b1;
                    next_s.st = wc.block_clear ? ST_ERASE : ST_PROG;
                    next_s.blk = s.tptr[TP_WIDTH-1:BLK_LSB];
                end
            end
        end

        if (write && !busy && address == OFS_TPTR)
            next_s.tptr = tptr_merged[TP_WIDTH-1:0];

        if (write && address == OFS_STAT)
            next_s.stat = fbe_w1c(s.stat, writedata, byteenable);

        if (write && address == OFS_MASK && byteenable[0]) begin
            next_s.mask      = fbe_evt_t'(writedata[7:0]);
            next_s.mask.rsvd = '0;
        end

        // Hardware events come last so a set beats a clear
        unique case (s.st)
            ST_IDLE: begin
            end
            ST_ERASE, ST_PROG: begin
                if (t_done) begin
                    next_s.st          = ST_IDLE;
                    next_s.ctl.prog_go = 1'b0;
                    next_s.stat.done   = 1'b1;
                    if (s.st == ST_ERASE)
                        next_s.ctl.block_clear = 1'b0;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        if (dev_reset) begin
            next_s.ctl.permit      = 1'b0;
            next_s.ctl.prog_go     = 1'b0;
            next_s.ctl.fetch_go    = 1'b0;
            next_s.ctl.block_clear = 1'b0;
            next_s.st              = ST_IDLE;
            t_start                = 1'b0;
            if (busy) begin
                t_abort          = 1'b1;
                next_s.ctl.fault = 1'b1;
                next_s.stat.fault = 1'b1;
                next_s.ctl.mem_sel = s.ctl.mem_sel;
                next_s.ctl.cfg_sel = s.ctl.cfg_sel;
            end
        end

        next_s.ctl.rsvd = 1'b0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            s <= TOP_RESET;
        else
            s <= next_s;
    end

    // Outputs
    assign readdata    = s.rdata;
    assign waitrequest = rd_take;
    assign irq         = |(s.stat & s.mask);
    assign eeprom_read = s.ctl.fetch_go;
    assign cpu_stall   = busy;

    assign nvm_cmd.erase   = (s.st == ST_ERASE);
    assign nvm_cmd.write   = (s.st == ST_PROG);
    assign nvm_cmd.mem_sel = s.ctl.mem_sel;
    assign nvm_cmd.cfg_sel = s.ctl.cfg_sel;
    assign nvm_cmd.block   = s.blk;

    // Assertion helper only; counts the cycles of the running stall
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            stall_len <= 0;
        else if (cpu_stall)
            stall_len <= stall_len + 1;
        else
            stall_len <= 0;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_start_keyed: assert property (
        $rose(busy) |-> $past(key_armed) && $past(ctrl_wr)
            && $past(wc.prog_go))
        else $error("cycle started without unlock key");

    a_start_permit: assert property (
        $rose(busy) |-> $past(s.ctl.permit))
        else $error("cycle started without permit");

    a_erase_select: assert property (
        $rose(nvm_cmd.erase) |-> $past(wc.block_clear)
            && s.ctl.block_clear)
        else $error("erase began without block clear");

    a_block_addr: assert property (
        $rose(busy) |-> nvm_cmd.block == $past(s.tptr[TP_WIDTH-1:BLK_LSB]))
        else $error("erase block not from pointer 21:6");

    a_block_steady: assert property (
        nvm_cmd.erase && $past(nvm_cmd.erase) |-> $stable(nvm_cmd.block))
        else $error("block address moved during erase");

    a_stall_cover: assert property (
        $rose(busy) |-> cpu_stall [*8])
        else $error("processor not stalled during cycle");

    a_done_clears: assert property (
        t_done && s.st == ST_ERASE && !dev_reset |=>
            !s.ctl.prog_go && !s.ctl.block_clear && !busy
            && s.stat.done)
        else $error("erase completion did not clear go and block clear");

    a_go_held: assert property (
        busy && !t_done && !dev_reset |=> s.ctl.prog_go && busy)
        else $error("program go dropped before timer expiry");

    a_fetch_block: assert property (
        s.ctl.fetch_go |-> !$past(s.ctl.mem_sel) && !$past(s.ctl.cfg_sel)
            ##1 !s.ctl.fetch_go)
        else $error("fetch go set while blocked or not self-cleared");

    a_abort_fault: assert property (
        dev_reset && busy |=> s.ctl.fault && !busy
            && $stable(s.ctl.mem_sel) && $stable(s.ctl.cfg_sel))
        else $error("reset during cycle lost fault or selects");

    a_timer_pair: assert property (
        $fell(busy) && !$past(dev_reset) |-> $past(t_done))
        else $error("cycle ended without timer expiry");

    a_irq_event: assert property (
        $rose(s.stat.done) && s.mask.done |-> irq)
        else $error("unmasked done did not raise interrupt");

    a_stall_length: assert property (
        $fell(cpu_stall) && !$past(dev_reset) |-> stall_len == ERASE_CYC)
        else $error("stall did not last the programmed cycle count");

    a_refuse_nokey: assert property (
        ctrl_wr && wc.prog_go && !key_armed && !busy
            |=> !busy && !s.ctl.prog_go)
        else $error("go without unlock key started a cycle");

    a_key_spent: assert property (
        ctrl_wr && wc.prog_go && !busy |=> !key_armed)
        else $error("go attempt left the unlock key armed");

    a_refuse_permit: assert property (
        ctrl_wr && wc.prog_go && !s.ctl.permit && !busy
            |=> !busy && !s.ctl.prog_go)
        else $error("go without permit started a cycle");

    a_ctl_frozen: assert property (
        ctrl_wr && busy && !t_done && !dev_reset
            |=> $stable({s.ctl.mem_sel, s.ctl.cfg_sel, s.ctl.block_clear,
                         s.ctl.permit, s.ctl.prog_go}))
        else $error("control changed by software during a cycle");

    a_prog_done: assert property (
        t_done && s.st == ST_PROG && !dev_reset |=> !s.ctl.prog_go
            && !busy && s.stat.done && $stable(s.ctl.block_clear))
        else $error("program completion did not end cleanly");

    a_abort_status: assert property (
        dev_reset && busy |=> s.stat.fault && !cpu_stall)
        else $error("cut cycle did not flag a fault event");

endmodule : fbe_block_erase

// *** tb/fbe_block_erase_tb.sv ***
// Self-checking bench for the flash block erase controller
`timescale 1ns/100ps
module fbe_block_erase_tb;
    import fbe_pkg::*;

    // Short erase so the run stays brief
    localparam int CYC = 20;

    // System
    logic                 clock;
    logic                 rst;
    logic                 dev_reset;
    // Register bus
    logic [4:0]           address;
    logic                 read;
    logic                 write;
    logic [31:0]          writedata;
    logic [3:0]           byteenable;
    logic [31:0]          readdata;
    logic                 waitrequest;
    // Flash and core side
    fbe_nvm_cmd_t         nvm_cmd;
    logic                 eeprom_read;
    logic                 cpu_stall;
    logic                 irq;

    int                   failures;
    int                   checks;
    int                   n_stall;
    int                   n_erase;
    int                   n_write;
    int                   n_fetch;
    int                   n_blk;
    logic [BLK_WIDTH-1:0] exp_blk;
    logic [21:0]          ptr;
    logic [31:0]          m_ctrl;

    fbe_block_erase #(.ERASE_CYC(CYC)) uut (
        .clock(clock), .rst(rst), .dev_reset(dev_reset),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .nvm_cmd(nvm_cmd), .eeprom_read(eeprom_read),
        .cpu_stall(cpu_stall), .irq(irq)
    );

    always #20 clock = ~clock;

    // Counted mid-cycle, clear of the edge updates
    always @(negedge clock) begin
        if (cpu_stall === 1'b1) n_stall++;
        if (nvm_cmd.erase === 1'b1) n_erase++;
        if (nvm_cmd.write === 1'b1) n_write++;
        if (eeprom_read === 1'b1) n_fetch++;
        // Every cycle run here targets program flash
        if (cpu_stall === 1'b1 && (nvm_cmd.block !== exp_blk
            || nvm_cmd.mem_sel !== 1'b1 || nvm_cmd.cfg_sel !== 1'b0)) n_blk++;
    end

    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait for the slave to drop waitrequest
    task automatic wait_ack;
        int i;
        i = 0;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            i++;
            if (i > 8) begin
                failures++;
                $display("BAD waitrequest expected 0 seen 1");
                summarize();
            end
            @(posedge clock);
        end
    endtask : wait_ack

    task automatic wr(logic [4:0] a, logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= 1'b1;
        wait_ack();
        write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rdchk(string what, logic [4:0] a, logic [31:0] exp);
        logic [31:0] d;
        address <= a;
        read    <= 1'b1;
        wait_ack();
        d = readdata;
        read <= 1'b0;
        @(posedge clock);
        chk(what, exp, d);
    endtask : rdchk

    task automatic zero;
        n_stall = 0;
        n_erase = 0;
        n_write = 0;
        n_fetch = 0;
        n_blk   = 0;
    endtask : zero

    task automatic unlock;
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
    endtask : unlock

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        dev_reset = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        failures = 0;
        checks = 0;
        exp_blk = '0;
        zero();
        void'($urandom(16));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);

        rdchk("ctrl", OFS_CTRL, 32'h00);
        rdchk("stat", OFS_STAT, 32'h00);
        rdchk("mask", OFS_MASK, 32'h00);
        rdchk("ptr", OFS_TPTR, 32'h00);
        wr(5'h14, 32'hFF);
        rdchk("unmapped", 5'h14, 32'h00);
        rdchk("key port", OFS_KEY, 32'h00);
        $display("TEST reset done");

        // Pass 0 erases, pass 1 runs a plain program cycle, irq masked
        for (int k = 0; k < 2; k++) begin
            ptr = 22'($urandom());
            wr(OFS_TPTR, {10'h0, ptr});
            rdchk("ptr", OFS_TPTR, {10'h0, ptr});
            exp_blk = ptr[21:6];
            wr(OFS_MASK, (k == 0) ? 32'h1 : 32'h0);
            m_ctrl = (k == 0) ? 32'h94 : 32'h84;
            wr(OFS_CTRL, m_ctrl);
            unlock();
            zero();
            wr(OFS_CTRL, m_ctrl | 32'h2);
            repeat (CYC + 5) @(posedge clock);
            chk("stall cycles", CYC, n_stall);
            chk("erase cycles", (k == 0) ? CYC : 0, n_erase);
            chk("write cycles", (k == 0) ? 0 : CYC, n_write);
            chk("block mismatches", 0, n_blk);
            rdchk("ctrl after", OFS_CTRL, 32'h84);
            rdchk("stat done", OFS_STAT, 32'h1);
            chk("irq", (k == 0) ? 32'h1 : 32'h0, {31'h0, irq});
            wr(OFS_STAT, 32'h1);
            rdchk("stat cleared", OFS_STAT, 32'h0);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        $display("TEST erase and program done");

        // Refused: no key, broken key, permit not set beforehand
        for (int k = 0; k < 3; k++) begin
            m_ctrl = (k == 2) ? 32'h90 : 32'h84;
            wr(OFS_CTRL, m_ctrl);
            if (k == 1) begin
                wr(OFS_KEY, 32'h55);
                wr(OFS_KEY, 32'h33);
                wr(OFS_KEY, 32'hAA);
            end
            if (k == 2) unlock();
            zero();
            wr(OFS_CTRL, m_ctrl | 32'h2);
            repeat (4) @(posedge clock);
            chk("refused stall", 0, n_stall);
            rdchk("refused ctrl", OFS_CTRL, m_ctrl);
        end
        $display("TEST refused starts done");

        // Fetch go allowed only with both selects clear
        for (int k = 0; k < 3; k++) begin
            m_ctrl = (k == 0) ? 32'h00 : ((k == 1) ? 32'h80 : 32'h40);
            wr(OFS_CTRL, m_ctrl);
            zero();
            wr(OFS_CTRL, m_ctrl | 32'h1);
            @(posedge clock);
            chk("fetch pulses", (k == 0) ? 1 : 0, n_fetch);
            rdchk("fetch ctrl", OFS_CTRL, m_ctrl);
        end
        $display("TEST fetch done");

        // Device reset cuts an erase short
        wr(OFS_MASK, 32'h3);
        wr(OFS_CTRL, 32'h94);
        unlock();
        zero();
        wr(OFS_CTRL, 32'h96);
        rdchk("go during erase", OFS_CTRL, 32'h96);
        wr(OFS_CTRL, 32'h94);
        rdchk("write while stalled", OFS_CTRL, 32'h96);
        dev_reset <= 1'b1;
        @(posedge clock);
        dev_reset <= 1'b0;
        repeat (2) @(posedge clock);
        chk("stall after abort", 32'h0, {31'h0, cpu_stall});
        rdchk("ctrl after abort", OFS_CTRL, 32'h88);
        rdchk("stat after abort", OFS_STAT, 32'h2);
        chk("irq fault", 32'h1, {31'h0, irq});
        $display("TEST abort done");

        summarize();
    end
endmodule : fbe_block_erase_tb
